// >>> elacap_pkg.sv
// package of constants for the embedded logic analyzer capture block
package elacap_pkg;
  localparam int unsigned PROBE_W     = 8;   // probed signal width
  localparam int unsigned TRIG_W      = 8;   // trigger input width
  localparam int unsigned DEPTH       = 32;  // sample buffer depth
  localparam int unsigned ADDR_W      = 5;   // buffer index width
  localparam int unsigned FIFO_DEPTH  = 32;  // readback fifo depth
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00; // write index after reset
  localparam logic [ADDR_W:0]   CNT_RST  = 6'h00; // fill count after reset
  localparam logic [PROBE_W-1:0] DATA_RST = 8'h00; // sample word after reset

  // capture state, one-hot
  typedef enum logic [3:0] {
    ELA_IDLE = 4'b0001,
    ELA_ARM  = 4'b0010,
    ELA_DONE = 4'b0100,
    ELA_READ = 4'b1000
  } elacap_state_t;
endpackage

// >>> elacap_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module elacap_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 32,
  parameter int unsigned A = 5
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] mem [D];   // storage in flip-flops
  logic [A-1:0] wr_ptr;    // write index
  logic [A-1:0] rd_ptr;    // read index
  logic [A:0]   count;     // words held
  logic         push;
  logic         pop;

  assign in_ready_o  = (count != D[A:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // storage write, no reset needed on data
  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> elacap_top.sv
// embedded logic analyzer capture core: trigger, sample buffer, readback
// Operation
// - all sampling happens on the one core clock
// - probe bus stored each clock as sample
// - trigger condition uses separate trigger bus
// - external trigger input can fire trigger
// - trigger occurred output raised after trigger
// - condition becoming true is the trigger event
// - single run stops storing at trigger
// - continuous mode captures until stop request
// - stop without trigger gives no completed capture
// - buffer readable even without trigger
// - store in memory or route to pins
// - one debug output per routed signal
`timescale 1ns/1ns
`default_nettype none
module elacap_top
  import elacap_pkg::*;
(
  input  wire logic                         core_clk_i,      // sampling clock
  input  wire logic                         nrst_i,          // async reset, low
  input  wire logic [elacap_pkg::PROBE_W-1:0] probe_i,       // monitored signals
  input  wire logic [elacap_pkg::TRIG_W-1:0]  trig_cond_i,   // trigger signals
  input  wire logic [elacap_pkg::TRIG_W-1:0]  trig_pattern_i,// pattern to match
  input  wire logic [elacap_pkg::TRIG_W-1:0]  trig_care_i,   // bits that count
  input  wire logic                         trig_cond_en_i,  // use trigger bus
  input  wire logic                         ext_trig_en_i,   // use external trigger
  input  wire logic                         ext_trig_i,      // external trigger
  input  wire logic                         run_req_i,       // single run pulse
  input  wire logic                         continuous_capture_mode_i, // auto run pulse
  input  wire logic                         stop_req_i,      // stop pulse
  input  wire logic                         read_req_i,      // readback pulse
  input  wire logic                         pin_route_i,     // 1: route to pins
  output logic                              trig_out_o,      // trigger occurred
  output logic                              busy_o,          // analysis running
  output logic                              capture_valid_o, // completed capture
  output logic [elacap_pkg::PROBE_W-1:0]    debug_out_o,     // routed probes
  output logic [elacap_pkg::PROBE_W-1:0]    rd_data_o,       // readback word
  output logic                              rd_valid_o,      // readback valid
  input  wire logic                         rd_ready_i       // host takes word
);
  import elacap_pkg::*;

  elacap_state_t           state;        // capture state
  elacap_state_t           next_state;   // next capture state
  logic                    auto_mode;    // continuous capture latched
  logic [PROBE_W-1:0]      buf_mem [DEPTH]; // sample buffer in flip-flops
  logic [ADDR_W-1:0]       wr_idx;       // next buffer slot
  logic [ADDR_W:0]         fill;         // valid samples held
  logic [ADDR_W-1:0]       rd_idx;       // readback slot
  logic [ADDR_W:0]         rd_left;      // words left to read
  logic                    cond_now;     // trigger condition level
  logic                    cond_prev;    // condition one clock ago
  logic                    trig_evt;     // trigger event this clock
  logic                    store_en;     // sample stored this clock
  logic                    run_start;    // run or continuous request taken
  logic                    fifo_in_ready;// fifo accepts word
  logic                    fifo_in_valid;// readback word offered
  logic [PROBE_W-1:0]      fifo_out_data; // fifo head word
  logic                    fifo_out_valid;// fifo holds a word

  // condition is a masked pattern match or the external pin
  always_comb
  begin
    cond_now = 1'b0;
    if (trig_cond_en_i && (((trig_cond_i ^ trig_pattern_i) & trig_care_i) == '0))
    begin
      cond_now = 1'b1;
    end
    if (ext_trig_en_i && ext_trig_i)
    begin
      cond_now = 1'b1;
    end
  end

  // only a rising condition counts, so a stuck-true condition fires at most once, and never if already true at arm
  assign trig_evt = (state == ELA_ARM) && cond_now && !cond_prev;

  // memory mode stores while armed; pin mode never fills the buffer; a single run
  // drops the trigger-clock sample, a continuous run keeps every armed sample
  assign store_en = (state == ELA_ARM) && !pin_route_i
                    && !(trig_evt && !auto_mode);

  // a start is taken only from idle or done; it opens a fresh capture
  assign run_start = (state != ELA_ARM) && (next_state == ELA_ARM);

  // condition history for edge detection
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cond_prev <= 1'b0;
    end
    else
    begin
      cond_prev <= cond_now;
    end
  end

  // next state from host requests and trigger
  always_comb
  begin
    next_state = state;
    case (state)
      ELA_IDLE:
      begin
        // a start wins over a read in the same clock
        if (run_req_i || continuous_capture_mode_i)
        begin
          next_state = ELA_ARM;
        end
        else if (read_req_i)
        begin
          next_state = ELA_READ;
        end
      end
      ELA_ARM:
      begin
        // stop wins over a trigger in the same clock
        if (stop_req_i)
        begin
          next_state = ELA_IDLE;
        end
        else if (trig_evt && !auto_mode)
        begin
          next_state = ELA_DONE;
        end
      end
      ELA_DONE:
      begin
        // a finished capture waits here until read or rearmed
        if (read_req_i)
        begin
          next_state = ELA_READ;
        end
        else if (run_req_i || continuous_capture_mode_i)
        begin
          next_state = ELA_ARM;
        end
      end
      ELA_READ:
      begin
        // leave once every held word went into the fifo
        if (rd_left == '0)
        begin
          next_state = ELA_IDLE;
        end
      end
      default:
      begin
        next_state = ELA_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= ELA_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // continuous mode latch: taken with each accepted start, so a request that
  // the state machine refuses cannot change the mode of the next run
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      auto_mode <= 1'b0;
    end
    else if (stop_req_i && (state == ELA_ARM))
    begin
      auto_mode <= 1'b0;
    end
    else if (run_start)
    begin
      auto_mode <= continuous_capture_mode_i;
    end
  end

  // sample storage: circular, so the buffer holds the newest samples
  always_ff @(posedge core_clk_i)
  begin
    if (store_en)
    begin
      buf_mem[wr_idx] <= probe_i;
    end
  end

  // write index and fill count; a new run clears the old capture
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_idx <= ADDR_RST;
      fill   <= CNT_RST;
    end
    else if (run_start)
    begin
      wr_idx <= ADDR_RST;
      fill   <= CNT_RST;
    end
    else if (store_en)
    begin
      wr_idx <= wr_idx + 1'b1;
      if (fill != DEPTH[ADDR_W:0])
      begin
        fill <= fill + 1'b1;
      end
    end
  end

  // readback walker: oldest sample first, stalls on fifo back-pressure
  // once the buffer has wrapped, the oldest sample sits at the write index
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_idx  <= ADDR_RST;
      rd_left <= CNT_RST;
    end
    else if ((state != ELA_READ) && (next_state == ELA_READ))
    begin
      rd_idx  <= (fill == DEPTH[ADDR_W:0]) ? wr_idx : ADDR_RST;
      rd_left <= fill;
    end
    else if (fifo_in_valid && fifo_in_ready)
    begin
      rd_idx  <= rd_idx + 1'b1;
      rd_left <= rd_left - 1'b1;
    end
  end

  // offer buffer words only while reading and some are left
  assign fifo_in_valid = (state == ELA_READ) && (rd_left != '0);

  // readback buffer toward the host port
  elacap_fifo #(
    .W (PROBE_W),
    .D (FIFO_DEPTH),
    .A (ADDR_W)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .in_data_i   (buf_mem[rd_idx]),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rd_ready_i && rd_valid_o)
  );

  // registered readback output stage, refilled as host takes words
  // the head word is copied here and popped only when the host takes it;
  // this costs one idle clock between words but keeps the output a flip-flop
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= DATA_RST;
    end
    else if (!rd_valid_o || rd_ready_i)
    begin
      rd_valid_o <= fifo_out_valid && !(rd_valid_o && rd_ready_i);
      rd_data_o  <= fifo_out_data;
    end
  end

  // trigger occurred flag, held until the next start is taken; a stop in the
  // same clock as the event wins, so a run stopped at its trigger event reports no trigger
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      trig_out_o <= 1'b0;
    end
    else if (run_start)
    begin
      trig_out_o <= 1'b0;
    end
    else if (trig_evt && !stop_req_i)
    begin
      trig_out_o <= 1'b1;
    end
  end

  // completed capture flag; a stop with no trigger leaves it low, although
  // the buffer can still be read back
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      capture_valid_o <= 1'b0;
    end
    else if (run_start)
    begin
      capture_valid_o <= 1'b0;
    end
    else if (trig_evt && !stop_req_i)
    begin
      capture_valid_o <= 1'b1;
    end
  end

  // busy is the registered next state, so it is high exactly while armed
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= (next_state == ELA_ARM);
    end
  end

  // pin routing, one registered debug output per probe bit; the pins rest
  // at zero in memory mode so unused outputs do not toggle
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      debug_out_o <= DATA_RST;
    end
    else if (pin_route_i)
    begin
      debug_out_o <= probe_i;
    end
    else
    begin
      debug_out_o <= DATA_RST;
    end
  end
endmodule
`default_nettype wire

// >>> elacap_user_model.sv
// user-side model: drives the probed bus and the trigger bus
`timescale 1ns/1ns
`default_nettype none
module elacap_user_model (
  input  wire logic                            core_clk_i,
  input  wire logic                            nrst_i,     // async reset, low
  input  wire logic                            fire_i,     // raise trigger bus value
  input  wire logic [elacap_pkg::TRIG_W-1:0]   fire_val_i, // value shown when fired
  output logic      [elacap_pkg::PROBE_W-1:0]  probe_o,    // counting probe pattern
  output logic      [elacap_pkg::TRIG_W-1:0]   cond_o      // trigger bus
);
  import elacap_pkg::*;
  // probe counts each clock so buffer order shows in readback
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      probe_o <= 8'h00;
    else
      probe_o <= probe_o + 8'h01;
  end
  // trigger bus is kept apart from the probe bus; idle value never matches
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cond_o <= 8'h00;
    else
      cond_o <= fire_i ? fire_val_i : 8'h00;
  end
endmodule
`default_nettype wire

// >>> elacap_checker.sv
// assertion checker for the capture core top ports
`timescale 1ns/1ns
`default_nettype none
module elacap_checker (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] probe_i,
  input wire logic [7:0] trig_cond_i,
  input wire logic [7:0] trig_pattern_i,
  input wire logic [7:0] trig_care_i,
  input wire logic       trig_cond_en_i,
  input wire logic       ext_trig_en_i,
  input wire logic       ext_trig_i,
  input wire logic       run_req_i,
  input wire logic       continuous_capture_mode_i,
  input wire logic       stop_req_i,
  input wire logic       pin_route_i,
  input wire logic       trig_out_o,
  input wire logic       busy_o,
  input wire logic       capture_valid_o,
  input wire logic [7:0] debug_out_o
);
  logic hit;    // some enabled trigger source is true
  logic start;  // start request while not armed
  logic auto_q; // last start seen while not armed was continuous
  assign hit = (trig_cond_en_i && ((trig_cond_i ^ trig_pattern_i) & trig_care_i) == 8'h00)
    || (ext_trig_en_i && ext_trig_i);
  assign start = (run_req_i || continuous_capture_mode_i) && !busy_o;
  // mode memory, since no port shows the mode
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      auto_q <= 1'h0;
    else if (start)
      auto_q <= continuous_capture_mode_i;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_armed; busy_o && $past(busy_o); endsequence
  sequence s_rise; hit && !$past(hit) && !stop_req_i; endsequence
  property p_rise_fires; s_armed and s_rise |=> trig_out_o && capture_valid_o; endproperty
  a_rise_fires: assert property (p_rise_fires) else $error("trigger edge missed");
  property p_run_arms; start |=> busy_o && !trig_out_o; endproperty
  a_run_arms: assert property (p_run_arms) else $error("start not taken");
  property p_stop_halts; stop_req_i && busy_o |=> !busy_o; endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("stop ignored");
  property p_stop_empty; stop_req_i && busy_o && !trig_out_o |=> !capture_valid_o; endproperty
  a_stop_empty: assert property (p_stop_empty) else $error("capture shown");
  property p_single_ends; $rose(trig_out_o) && !auto_q |-> !busy_o; endproperty
  a_single_ends: assert property (p_single_ends) else $error("single run kept on");
  property p_auto_keeps; $rose(trig_out_o) && auto_q |-> busy_o; endproperty
  a_auto_keeps: assert property (p_auto_keeps) else $error("continuous run ended");
  property p_trig_holds; trig_out_o && !start |=> trig_out_o; endproperty
  a_trig_holds: assert property (p_trig_holds) else $error("trigger flag dropped");
  property p_valid_pair; capture_valid_o |-> trig_out_o; endproperty
  a_valid_pair: assert property (p_valid_pair) else $error("capture without trigger");
  property p_pin_copy; pin_route_i |=> debug_out_o == $past(probe_i); endproperty
  a_pin_copy: assert property (p_pin_copy) else $error("debug pins wrong");
  property p_pin_quiet; !pin_route_i |=> debug_out_o == 8'h00; endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("debug pins driven");
endmodule
`default_nettype wire

// >>> elacap_top_tb.sv
// self-checking bench for the capture core
`timescale 1ns/1ns
`default_nettype none
module elacap_top_tb;
  import elacap_pkg::*;
  typedef struct packed {
    logic cen; logic een; logic aut; logic [7:0] pat; logic [7:0] care; logic [7:0] fv; logic hit;
  } elacap_row_t;
  // ordinary cases: sources, mode, pattern, care, fired value, trigger expected
  localparam elacap_row_t ROWS [6] = '{
    {3'b100, 8'hA5, 8'hFF, 8'hA5, 1'b1}, {3'b100, 8'hA5, 8'h0F, 8'h35, 1'b1},
    {3'b100, 8'hA5, 8'hFF, 8'hA4, 1'b0}, {3'b010, 8'hA5, 8'hFF, 8'h00, 1'b1},
    {3'b011, 8'hA5, 8'hFF, 8'h00, 1'b1}, {3'b000, 8'hA5, 8'hFF, 8'hA5, 1'b0}};
  logic       clk = 1'h0, nrst = 1'h0, cen = 1'h0, een = 1'h0, ext = 1'h0;
  logic       pin = 1'h0, rdy = 1'h0, fire = 1'h0, tout, busy, cval, rval;
  logic [3:0] req = 4'h0; // run, continuous, stop, read pulses
  logic [7:0] pat = 8'h00, care = 8'h00, fv = 8'h00, probe, cond, dbg, rdat;
  int         err_count = 0, tests_run = 0;
  elacap_row_t r;
  always #25 clk = ~clk;
  elacap_user_model i_model (.core_clk_i(clk), .nrst_i(nrst), .fire_i(fire),
    .fire_val_i(fv), .probe_o(probe), .cond_o(cond));
  elacap_top i_dut (.core_clk_i(clk), .nrst_i(nrst), .probe_i(probe), .trig_cond_i(cond),
    .trig_pattern_i(pat), .trig_care_i(care), .trig_cond_en_i(cen), .ext_trig_en_i(een),
    .ext_trig_i(ext), .run_req_i(req[0]), .continuous_capture_mode_i(req[1]),
    .stop_req_i(req[2]), .read_req_i(req[3]), .pin_route_i(pin), .trig_out_o(tout),
    .busy_o(busy), .capture_valid_o(cval), .debug_out_o(dbg), .rd_data_o(rdat),
    .rd_valid_o(rval), .rd_ready_i(rdy));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp, input string what);
    chk_bit(got === exp, 1'h1, what);
  endtask
  // one-cycle request pulse, raised and lowered on rising edges
  task automatic pulse(input int k);
    @(posedge clk);
    req[k] <= 1'h1;
    @(posedge clk);
    req <= 4'h0;
  endtask
  // host stalls first, then drains; words must be 32 consecutive samples
  task automatic read_back;
    int n;
    logic [7:0] prev;
    n = 0;
    pulse(3);
    cyc(10);
    chk_bit(rval, 1'h1, "word waits");
    @(posedge clk) rdy <= 1'h1;
    for (int k = 0; k < 100 && n < 32; k++)
    begin
      @(negedge clk);
      if (rval === 1'h1)
      begin
        if (n > 0) chk_word(rdat, prev + 8'h01, "order");
        prev = rdat;
        n++;
      end
    end
    @(posedge clk) rdy <= 1'h0;
    cyc(4);
    chk_bit(n == 32 && rval === 1'h0, 1'h1, "word count");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    cyc(1);
    chk_bit(tout | busy | cval | rval, 1'h0, "reset quiet");
    chk_word(dbg | rdat, 8'h00, "reset pins");
    @(posedge clk) nrst <= 1'h1;
    $display("reset done");
    for (int i = 0; i < 6; i++)
    begin
      r = ROWS[i];
      @(posedge clk);
      {cen, een, pat, care, fv} <= {r.cen, r.een, r.pat, r.care, r.fv};
      pulse(r.aut ? 1 : 0);
      @(negedge clk);
      chk_bit(busy & ~tout, 1'h1, "armed");
      cyc(40);
      @(posedge clk) {fire, ext} <= 2'h3;
      cyc(3);
      chk_bit(tout, r.hit, "trigger out");
      chk_bit(busy, ~r.hit | r.aut, "busy after trigger");
      @(posedge clk) {fire, ext} <= 2'h0;
      pulse(2);
      cyc(2);
      chk_bit(busy, 1'h0, "stopped");
      chk_bit(cval, r.hit, "completed capture");
      read_back();
      $display("case %0d done", i);
    end
    @(posedge clk) pin <= 1'h1;
    cyc(3);
    chk_word(dbg, probe - 8'h01, "pin copy");
    @(posedge clk) pin <= 1'h0;
    cyc(2);
    chk_word(dbg, 8'h00, "pins quiet");
    $display("pin routing done");
    @(posedge clk) {cen, een, ext} <= 3'h3;
    pulse(0);
    cyc(5);
    chk_bit(tout, 1'h0, "level at arm");
    @(posedge clk) ext <= 1'h0;
    cyc(3);
    @(posedge clk) {ext, req} <= 5'h14;
    @(posedge clk) req <= 4'h0;
    cyc(2);
    chk_bit(tout | cval | busy, 1'h0, "stop wins");
    $display("stop race done");
    test_done();
  end
endmodule
bind elacap_top elacap_checker i_chk (
  .core_clk_i                (core_clk_i),
  .nrst_i                    (nrst_i),
  .probe_i                   (probe_i),
  .trig_cond_i               (trig_cond_i),
  .trig_pattern_i            (trig_pattern_i),
  .trig_care_i               (trig_care_i),
  .trig_cond_en_i            (trig_cond_en_i),
  .ext_trig_en_i             (ext_trig_en_i),
  .ext_trig_i                (ext_trig_i),
  .run_req_i                 (run_req_i),
  .continuous_capture_mode_i (continuous_capture_mode_i),
  .stop_req_i                (stop_req_i),
  .pin_route_i               (pin_route_i),
  .trig_out_o                (trig_out_o),
  .busy_o                    (busy_o),
  .capture_valid_o           (capture_valid_o),
  .debug_out_o               (debug_out_o)
);
`default_nettype wire
